// ==== common/rtcw_defines.vh ====
// register offsets, field positions, reset values and timing counts for the rtc block
`ifndef RTCW_DEFINES_VH
`define RTCW_DEFINES_VH
// ==========================================================
// host bridge registers (byte addresses)
`define RTCW_OFF_ID 8'h00
`define RTCW_OFF_CTRL 8'h04
`define RTCW_OFF_LDATA 8'h08
`define RTCW_OFF_UDATA 8'h0c
`define RTCW_OFF_IEN 8'h10
`define RTCW_OFF_IFLG 8'h14
// host_access_control fields
`define RTCW_CTL_BUSY 31
`define RTCW_CTL_SIZE 25
`define RTCW_CTL_DIR 24
`define RTCW_CTL_UPPER_BYTE_ENABLES 23:20
`define RTCW_CTL_LOWER_BYTE_ENABLES 19:16
`define RTCW_CTL_ADDR 7:0
// host irq bits
`define RTCW_HI_XFER 0
`define RTCW_HI_SUB 1
// ==========================================================
// subsystem register indices
`define RTCW_SR_CTRL 8'h10
`define RTCW_SR_WDT 8'h11
`define RTCW_SR_TMR0 8'h12
`define RTCW_SR_TMR1 8'h13
`define RTCW_SR_CCTRL 8'h14
`define RTCW_SR_SEC 8'h15
`define RTCW_SR_MIN 8'h16
`define RTCW_SR_HOUR 8'h17
`define RTCW_SR_DAY0 8'h18
`define RTCW_SR_DAY1 8'h19
`define RTCW_SR_AMIN 8'h1a
`define RTCW_SR_AHOUR 8'h1b
`define RTCW_SR_ADAY0 8'h1c
`define RTCW_SR_ADAY1 8'h1d
`define RTCW_SR_CLKC 8'h20
// rtc control bits
`define RTCW_RC_TRE 0
`define RTCW_RC_TMODE 1
`define RTCW_RC_TIMER_IRQ_ENABLE 2
`define RTCW_RC_TFLG 3
`define RTCW_RC_WRST 4
`define RTCW_RC_WIEN 5
`define RTCW_RC_WFLG 6
`define RTCW_RC_WPEND 7
// calendar control bits
`define RTCW_CC_CALENDAR_ENABLE 0
`define RTCW_CC_ALARM_IRQ_ENABLE 1
`define RTCW_CC_MINUTE_MATCH_ENABLE 2
`define RTCW_CC_HOUR_MATCH_ENABLE 3
`define RTCW_CC_DAY_MATCH_ENABLE 4
`define RTCW_CC_AFLG 5
`define RTCW_CC_CPEND 7
// ==========================================================
// reset values and limits
`define RTCW_WDOG_RST 8'hff
`define RTCW_CLKC_RST 8'hb0
`define RTCW_SEC_MAX 8'h59
`define RTCW_MIN_MAX 8'h59
`define RTCW_HOUR_MAX 8'h23
`define RTCW_DAY_MAX 15'h7fff
// ==========================================================
// timing
`define RTCW_CLK_HZ 125000000
`define RTCW_OSC_HZ 32768
`define RTCW_SEC_LOG2 4'd15
`endif

// ==== rtl/rtcw_bcd2.v ====
// two-digit bcd counter with load and rollover carry
`timescale 1ns/100ps
`default_nettype none
module rtcw_bcd2 #(
	parameter [7:0] MAX = 8'h59
) (
	input wire clk_i,
	input wire srst_i,
	input wire inc_i,
	input wire ld_i,
	input wire [7:0] ld_val_i,
	output reg [7:0] val_o,
	output wire wrap_o
);
	// carry into the next field when stepping past the top value
	assign wrap_o = inc_i & (val_o == MAX);

	// a host load wins over a tick in the same cycle
	always @(posedge clk_i) begin
		if (srst_i) begin
			val_o <= 8'h00;
		end else if (ld_i) begin
			val_o <= ld_val_i;
		end else if (inc_i) begin
			if (val_o == MAX) begin
				val_o <= 8'h00;
			end else if (val_o[3:0] == 4'h9) begin
				val_o <= {val_o[7:4] + 4'h1, 4'h0};
			end else begin
				val_o <= val_o + 8'h01;
			end
		end
	end
endmodule // rtcw_bcd2
`default_nettype wire

// ==== rtl/rtcw_top.v ====
// rtc calendar, watchdog and down-timer behind the host access bridge
`timescale 1ns/100ps
`default_nettype none
`include "rtcw_defines.vh"
// Function
// - seconds and minutes count 0-59, hours 0-23, bcd, rolling over upward.
// - day count is binary 0 to 7fff in low byte and high 7-bit register.
// - watchdog is a free-running 8-bit down-counter with a reload control bit.
// - watchdog loads ff at reset, 256 ticks of 16 hz, about sixteen seconds.
// - watchdog at zero raises its event and reloads the programmed period.
// - enabled timer stops after one countdown or restarts, per mode bit.
// - timer expiry goes out as an event toward the interrupt controller.
// - timer low byte first; high byte write moves full 16 bits into counter.
// - after value divided by timer clock, timer expired flag sets.
// - writing watchdog value loads it into the 8-bit watchdog counter.
// - watchdog restart bit reloads the count and clears itself.
// - after count plus one divided by watchdog clock, watchdog expired flag sets.
// - calendar update pending bit shows; host waits for zero after writes.
// - calendar advances only when enabled; alarm event only when enabled.
// - alarm holds bcd minutes, bcd hours and 15-bit binary days.
// - writing the match enables clears the pending alarm flag first.
// - match enables select day-hour-minute, daily, hourly or no alarm.
// - size bit 0 means 4 bytes, 1 means 8; direction 0 write, 1 read.
// - two 4-bit byte enables gate bytes of each data register, bit 0 lsb.
// - 8-bit target index; lower data carries bytes 0-3, upper bytes 4-7.
module rtcw_top #(
	parameter OSC_DIV = `RTCW_CLK_HZ / `RTCW_OSC_HZ,
	parameter [31:0] PERIPH_ID = 32'h0000_0a01 // arbitrary value
) (
	input wire clk_i,
	input wire srst_i,
	input wire [7:0] host_addr_i,
	input wire host_wr_i,
	input wire host_rd_i,
	input wire [31:0] host_wdata_i,
	output reg [31:0] host_rdata_o,
	output reg host_irq_o,
	output reg tmr_event_o,
	output reg wdog_event_o,
	output reg alarm_event_o
);
	// cut to the prescaler width on purpose; the default divisor fits in 12 bits
	localparam integer PRE_M1 = OSC_DIV - 1;
	localparam [11:0] PRE_LAST = PRE_M1[11:0];
	localparam [1:0] BR_IDLE = 2'b01;
	localparam [1:0] BR_XFER = 2'b10;

	// ==========================================================
	// low-frequency time base
	// true when the low n bits of the oscillator count are all ones
	function div_hit;
		input [14:0] cnt;
		input [3:0] n;
		reg [15:0] m;
		begin
			m = (16'h0001 << n) - 16'h0001;
			div_hit = (({1'b0, cnt} & m) == m);
		end
	endfunction

	reg [11:0] pre_q;
	reg [14:0] lf_q;
	reg [7:0] clkc_q;
	wire osc_tick = (pre_q == PRE_LAST);
	wire sec_tick = osc_tick & div_hit(lf_q, `RTCW_SEC_LOG2);
	wire tmr_tick = osc_tick & div_hit(lf_q, clkc_q[3:0]);
	wire wdg_tick = osc_tick & div_hit(lf_q, clkc_q[7:4]);

	// prescaler stands in for the 32.768 khz oscillator
	always @(posedge clk_i) begin
		if (srst_i) begin
			pre_q <= 12'h000;
			lf_q <= 15'h0000;
		end else if (osc_tick) begin
			pre_q <= 12'h000;
			lf_q <= lf_q + 15'h0001;
		end else begin
			pre_q <= pre_q + 12'h001;
		end
	end

	// ==========================================================
	// host bridge state
	reg [1:0] br_q;
	reg size_q, dir_q;
	reg [3:0] upper_byte_enables_q, lower_byte_enables_q;
	reg [7:0] tgt_q;
	reg [2:0] idx_q;
	reg [63:0] xd_q;
	reg [1:0] ien_q, iflg_q;
	reg [7:0] sub_rd;
	wire busy = br_q[1];
	wire [7:0] ben = {upper_byte_enables_q, lower_byte_enables_q};
	wire lane_en = busy & ben[idx_q];
	wire [7:0] sub_addr = tgt_q + {5'h00, idx_q};
	wire sub_we = lane_en & ~dir_q;
	wire [7:0] sub_wd = xd_q[{idx_q, 3'b000} +: 8];
	wire xfer_last = busy & (idx_q == (size_q ? 3'd7 : 3'd3));
	wire ctl_wr = host_wr_i & (host_addr_i == `RTCW_OFF_CTRL) & ~busy;
	wire dat_wr = host_wr_i & ~busy;

	// one subsystem byte per cycle; skipped lanes still take their slot
	always @(posedge clk_i) begin
		if (srst_i) begin
			br_q <= BR_IDLE;
			size_q <= 1'b0;
			dir_q <= 1'b0;
			upper_byte_enables_q <= 4'h0;
			lower_byte_enables_q <= 4'h0;
			tgt_q <= 8'h00;
			idx_q <= 3'd0;
			xd_q <= 64'h0;
		end else begin
			case (br_q)
				BR_IDLE: begin
					if (ctl_wr) begin
						size_q <= host_wdata_i[`RTCW_CTL_SIZE];
						dir_q <= host_wdata_i[`RTCW_CTL_DIR];
						upper_byte_enables_q <= host_wdata_i[`RTCW_CTL_UPPER_BYTE_ENABLES];
						lower_byte_enables_q <= host_wdata_i[`RTCW_CTL_LOWER_BYTE_ENABLES];
						tgt_q <= host_wdata_i[`RTCW_CTL_ADDR];
						idx_q <= 3'd0;
						br_q <= BR_XFER;
					end
					if (dat_wr && host_addr_i == `RTCW_OFF_LDATA) begin
						xd_q[31:0] <= host_wdata_i;
					end
					if (dat_wr && host_addr_i == `RTCW_OFF_UDATA) begin
						xd_q[63:32] <= host_wdata_i;
					end
				end
				BR_XFER: begin
					if (lane_en && dir_q) begin
						xd_q[{idx_q, 3'b000} +: 8] <= sub_rd;
					end
					idx_q <= idx_q + 3'd1;
					if (xfer_last) begin
						br_q <= BR_IDLE;
					end
				end
				default: begin
					br_q <= BR_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// subsystem registers
	reg tre_q, tmode_q, timer_irq_enable_q, tflg_q;
	reg wrst_q, wien_q, wflg_q;
	reg [7:0] tmr_lo_q;
	reg [15:0] tmr_rl_q, tmr_cnt_q;
	reg tmr_ld_q, tmr_stop_q;
	reg [7:0] wdg_rl_q, wdg_cnt_q;
	reg wdg_ld_q;
	reg calendar_enable_q, alarm_irq_enable_q, minute_match_enable_q, hour_match_enable_q, day_match_enable_q, aflg_q, cpend_q;
	reg [14:0] day_q, aday_q;
	reg [7:0] amin_q, ahour_q;
	reg chk_q;
	wire [7:0] sec_v, min_v, hour_v;
	wire sec_wrap, min_wrap, hour_wrap;
	wire wpend = tmr_ld_q | wdg_ld_q | wrst_q;

	function wr_at;
		input [7:0] a;
		begin
			wr_at = sub_we & (sub_addr == a);
		end
	endfunction

	wire ctrl_we = wr_at(`RTCW_SR_CTRL);
	wire cctrl_we = wr_at(`RTCW_SR_CCTRL);

	// bcd time-of-day chain, stepped only while the calendar runs
	rtcw_bcd2 #(.MAX(`RTCW_SEC_MAX)) u_sec (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.inc_i(sec_tick & calendar_enable_q),
		.ld_i(wr_at(`RTCW_SR_SEC)),
		.ld_val_i(sub_wd),
		.val_o(sec_v),
		.wrap_o(sec_wrap)
	);
	rtcw_bcd2 #(.MAX(`RTCW_MIN_MAX)) u_min (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.inc_i(sec_wrap),
		.ld_i(wr_at(`RTCW_SR_MIN)),
		.ld_val_i(sub_wd),
		.val_o(min_v),
		.wrap_o(min_wrap)
	);
	rtcw_bcd2 #(.MAX(`RTCW_HOUR_MAX)) u_hour (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.inc_i(min_wrap),
		.ld_i(wr_at(`RTCW_SR_HOUR)),
		.ld_val_i(sub_wd),
		.val_o(hour_v),
		.wrap_o(hour_wrap)
	);

	// expiries; a pending reload takes the tick instead of the count
	wire tmr_go = tmr_tick & tre_q & ~tmr_stop_q & ~tmr_ld_q;
	wire tmr_exp = tmr_go & (tmr_cnt_q == 16'h0001);
	wire wdg_rel = osc_tick & (wdg_ld_q | wrst_q);
	wire wdg_exp = wdg_tick & ~wdg_rel & (wdg_cnt_q == 8'h00);
	// alarm checked once per minute boundary, after the new minute settles
	wire alarm_hit = chk_q & minute_match_enable_q & (min_v == amin_q) &
		(~hour_match_enable_q | (hour_v == ahour_q)) & (~day_match_enable_q | (day_q == aday_q));

	// subsystem read mux
	always @* begin
		case (sub_addr)
			`RTCW_SR_CTRL: sub_rd = {wpend, wflg_q, wien_q, wrst_q,
				tflg_q, timer_irq_enable_q, tmode_q, tre_q};
			`RTCW_SR_WDT: sub_rd = wdg_cnt_q;
			`RTCW_SR_TMR0: sub_rd = tmr_cnt_q[7:0];
			`RTCW_SR_TMR1: sub_rd = tmr_cnt_q[15:8];
			`RTCW_SR_CCTRL: sub_rd = {cpend_q, 1'b0, aflg_q, day_match_enable_q,
				hour_match_enable_q, minute_match_enable_q, alarm_irq_enable_q, calendar_enable_q};
			`RTCW_SR_SEC: sub_rd = sec_v;
			`RTCW_SR_MIN: sub_rd = min_v;
			`RTCW_SR_HOUR: sub_rd = hour_v;
			`RTCW_SR_DAY0: sub_rd = day_q[7:0];
			`RTCW_SR_DAY1: sub_rd = {1'b0, day_q[14:8]};
			`RTCW_SR_AMIN: sub_rd = amin_q;
			`RTCW_SR_AHOUR: sub_rd = ahour_q;
			`RTCW_SR_ADAY0: sub_rd = aday_q[7:0];
			`RTCW_SR_ADAY1: sub_rd = {1'b0, aday_q[14:8]};
			`RTCW_SR_CLKC: sub_rd = clkc_q;
			default: sub_rd = 8'h00;
		endcase
	end

	// down-timer: loads land on the next oscillator tick, like a slow domain
	always @(posedge clk_i) begin
		if (srst_i) begin
			tre_q <= 1'b0;
			tmode_q <= 1'b0;
			timer_irq_enable_q <= 1'b0;
			tflg_q <= 1'b0;
			tmr_lo_q <= 8'h00;
			tmr_rl_q <= 16'h0000;
			tmr_cnt_q <= 16'h0000;
			tmr_ld_q <= 1'b0;
			tmr_stop_q <= 1'b0;
			clkc_q <= `RTCW_CLKC_RST;
		end else begin
			if (ctrl_we) begin
				tre_q <= sub_wd[`RTCW_RC_TRE];
				tmode_q <= sub_wd[`RTCW_RC_TMODE];
				timer_irq_enable_q <= sub_wd[`RTCW_RC_TIMER_IRQ_ENABLE];
			end
			if (wr_at(`RTCW_SR_CLKC)) begin
				clkc_q <= sub_wd;
			end
			// expiry sets even when the clear arrives in the same cycle
			tflg_q <= tmr_exp | (tflg_q & ~(ctrl_we & sub_wd[`RTCW_RC_TFLG]));
			if (wr_at(`RTCW_SR_TMR0)) begin
				tmr_lo_q <= sub_wd;
			end
			if (wr_at(`RTCW_SR_TMR1)) begin
				tmr_rl_q <= {sub_wd, tmr_lo_q};
				tmr_ld_q <= 1'b1;
			end else if (osc_tick && tmr_ld_q) begin
				tmr_cnt_q <= tmr_rl_q;
				tmr_stop_q <= 1'b0;
				tmr_ld_q <= 1'b0;
			end else if (tmr_go && tmr_cnt_q != 16'h0000) begin
				if (tmr_cnt_q != 16'h0001) begin
					tmr_cnt_q <= tmr_cnt_q - 16'h0001;
				end else if (tmode_q) begin
					tmr_cnt_q <= tmr_rl_q;
				end else begin
					tmr_cnt_q <= 16'h0000;
					tmr_stop_q <= 1'b1;
				end
			end
		end
	end

	// watchdog: always counting, no enable can hold it
	always @(posedge clk_i) begin
		if (srst_i) begin
			wrst_q <= 1'b0;
			wien_q <= 1'b0;
			wflg_q <= 1'b0;
			wdg_rl_q <= `RTCW_WDOG_RST;
			wdg_cnt_q <= `RTCW_WDOG_RST;
			wdg_ld_q <= 1'b0;
		end else begin
			if (ctrl_we) begin
				wien_q <= sub_wd[`RTCW_RC_WIEN];
			end
			wflg_q <= wdg_exp | (wflg_q & ~(ctrl_we & sub_wd[`RTCW_RC_WFLG]));
			if (wr_at(`RTCW_SR_WDT)) begin
				wdg_rl_q <= sub_wd;
				wdg_ld_q <= 1'b1;
			end else if (wdg_rel) begin
				wdg_ld_q <= 1'b0;
			end
			if (ctrl_we && sub_wd[`RTCW_RC_WRST]) begin
				wrst_q <= 1'b1;
			end else if (wdg_rel) begin
				wrst_q <= 1'b0;
			end
			if (wdg_rel) begin
				wdg_cnt_q <= wdg_rl_q;
			end else if (wdg_exp) begin
				wdg_cnt_q <= wdg_rl_q;
			end else if (wdg_tick) begin
				wdg_cnt_q <= wdg_cnt_q - 8'h01;
			end
		end
	end

	// calendar day count, alarm registers and control
	always @(posedge clk_i) begin
		if (srst_i) begin
			calendar_enable_q <= 1'b0;
			alarm_irq_enable_q <= 1'b0;
			minute_match_enable_q <= 1'b0;
			hour_match_enable_q <= 1'b0;
			day_match_enable_q <= 1'b0;
			aflg_q <= 1'b0;
			cpend_q <= 1'b0;
			day_q <= 15'h0000;
			aday_q <= 15'h0000;
			amin_q <= 8'h00;
			ahour_q <= 8'h00;
			chk_q <= 1'b0;
		end else begin
			chk_q <= sec_wrap;
			if (cctrl_we) begin
				calendar_enable_q <= sub_wd[`RTCW_CC_CALENDAR_ENABLE];
				alarm_irq_enable_q <= sub_wd[`RTCW_CC_ALARM_IRQ_ENABLE];
				minute_match_enable_q <= sub_wd[`RTCW_CC_MINUTE_MATCH_ENABLE];
				hour_match_enable_q <= sub_wd[`RTCW_CC_HOUR_MATCH_ENABLE];
				day_match_enable_q <= sub_wd[`RTCW_CC_DAY_MATCH_ENABLE];
			end
			// any control write drops the old alarm; a fresh hit still wins
			aflg_q <= alarm_hit | (aflg_q & ~cctrl_we);
			// pending until the slow side has seen a tick after the write
			if (sub_we && sub_addr >= `RTCW_SR_CCTRL && sub_addr <= `RTCW_SR_ADAY1) begin
				cpend_q <= 1'b1;
			end else if (osc_tick) begin
				cpend_q <= 1'b0;
			end
			if (wr_at(`RTCW_SR_DAY0)) begin
				day_q[7:0] <= sub_wd;
			end else if (wr_at(`RTCW_SR_DAY1)) begin
				day_q[14:8] <= sub_wd[6:0];
			end else if (hour_wrap) begin
				day_q <= (day_q == `RTCW_DAY_MAX) ? 15'h0000 : day_q + 15'h0001;
			end
			if (wr_at(`RTCW_SR_AMIN)) begin
				amin_q <= sub_wd;
			end
			if (wr_at(`RTCW_SR_AHOUR)) begin
				ahour_q <= sub_wd;
			end
			if (wr_at(`RTCW_SR_ADAY0)) begin
				aday_q[7:0] <= sub_wd;
			end
			if (wr_at(`RTCW_SR_ADAY1)) begin
				aday_q[14:8] <= sub_wd[6:0];
			end
		end
	end

	// ==========================================================
	// events, host flags and read port
	wire any_evt = (tmr_exp & timer_irq_enable_q) | (wdg_exp & wien_q) | (alarm_hit & alarm_irq_enable_q);
	wire ifl_wr = host_wr_i & (host_addr_i == `RTCW_OFF_IFLG);

	always @(posedge clk_i) begin
		if (srst_i) begin
			tmr_event_o <= 1'b0;
			wdog_event_o <= 1'b0;
			alarm_event_o <= 1'b0;
			ien_q <= 2'b00;
			iflg_q <= 2'b00;
			host_irq_o <= 1'b0;
			host_rdata_o <= 32'h0;
		end else begin
			tmr_event_o <= tmr_exp & timer_irq_enable_q;
			wdog_event_o <= wdg_exp & wien_q;
			alarm_event_o <= alarm_hit & alarm_irq_enable_q;
			if (host_wr_i && host_addr_i == `RTCW_OFF_IEN) begin
				ien_q <= host_wdata_i[1:0];
			end
			// set wins over a write-one clear in the same cycle
			iflg_q[`RTCW_HI_XFER] <= xfer_last |
				(iflg_q[`RTCW_HI_XFER] & ~(ifl_wr & host_wdata_i[`RTCW_HI_XFER]));
			iflg_q[`RTCW_HI_SUB] <= any_evt |
				(iflg_q[`RTCW_HI_SUB] & ~(ifl_wr & host_wdata_i[`RTCW_HI_SUB]));
			host_irq_o <= |(iflg_q & ien_q);
			if (!host_rd_i) begin
				host_rdata_o <= 32'h0;
			end else begin
				case (host_addr_i)
					`RTCW_OFF_ID: host_rdata_o <= PERIPH_ID;
					`RTCW_OFF_CTRL: host_rdata_o <= {busy, 5'h00, size_q, dir_q,
						upper_byte_enables_q, lower_byte_enables_q, 8'h00, tgt_q};
					`RTCW_OFF_LDATA: host_rdata_o <= xd_q[31:0];
					`RTCW_OFF_UDATA: host_rdata_o <= xd_q[63:32];
					`RTCW_OFF_IEN: host_rdata_o <= {30'h0, ien_q};
					`RTCW_OFF_IFLG: host_rdata_o <= {30'h0, iflg_q};
					default: host_rdata_o <= 32'h0;
				endcase
			end
		end
	end
endmodule // rtcw_top
`default_nettype wire

// ==== verif/rtcw_host.sv ====
// host model: strobes bridge registers and runs subsystem transfers
`timescale 1ns/100ps
`default_nettype none
`include "rtcw_defines.vh"
module rtcw_host (
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [31:0] wdata_o
);
	// ==========================================================
	// idle bus; released lines show the inverse of the last value
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 32'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		addr_o <= ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask
	// ==========================================================
	// bridge transfers; no new request until busy reads clear
	task automatic poll();
		logic [31:0] s;
		s = 32'hffff_ffff;
		for (int n = 0; n < 30 && s[31] !== 1'b0; n++)
			rd(`RTCW_OFF_CTRL, s);
	endtask
	task automatic xfer(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi);
		wr(`RTCW_OFF_LDATA, lo);
		wr(`RTCW_OFF_UDATA, hi);
		wr(`RTCW_OFF_CTRL, c);
		poll();
	endtask
	task automatic sub_rd(input logic [7:0] i, output logic [7:0] b);
		logic [31:0] s;
		xfer({8'h01, 8'h01, 8'h00, i}, 32'h0, 32'h0);
		rd(`RTCW_OFF_LDATA, s);
		b = s[7:0];
	endtask
	// waits for a pending bit (bit 7) of a control register to drop
	task automatic hold(input logic [7:0] i);
		logic [7:0] b;
		b = 8'hff;
		for (int n = 0; n < 30 && b[7] !== 1'b0; n++)
			sub_rd(i, b);
	endtask
	task automatic sub_wr(input logic [7:0] i, input logic [7:0] b);
		if (i <= `RTCW_SR_TMR1)
			hold(`RTCW_SR_CTRL);
		xfer({16'h0001, 8'h00, i}, {24'h0, b}, 32'h0);
		if (i >= `RTCW_SR_CCTRL && i <= `RTCW_SR_ADAY1)
			hold(`RTCW_SR_CCTRL);
	endtask
endmodule // rtcw_host
`default_nettype wire

// ==== verif/rtcw_top_sva.sv ====
// concurrent checks on the rtc block host bus and event outputs
`timescale 1ns/100ps
`default_nettype none
`include "rtcw_defines.vh"
module rtcw_top_sva #(
	parameter [31:0] PERIPH_ID = 32'h0000_0a01 // arbitrary value
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] host_addr_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [31:0] host_wdata_i,
	input wire logic [31:0] host_rdata_o,
	input wire logic host_irq_o,
	input wire logic tmr_event_o,
	input wire logic wdog_event_o,
	input wire logic alarm_event_o
);
	// ==========================================================
	// shadow state
	logic [3:0] busy_q;
	logic [1:0] ien_q;
	wire start_w = host_wr_i && host_addr_i == `RTCW_OFF_CTRL && busy_q == 4'h0;
	// busy is modelled here so a stuck or short busy shows on a status read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			busy_q <= 4'h0;
			ien_q <= 2'h0;
		end else begin
			if (start_w)
				busy_q <= host_wdata_i[`RTCW_CTL_SIZE] ? 4'h8 : 4'h4;
			else if (busy_q != 4'h0)
				busy_q <= busy_q - 4'h1;
			if (host_wr_i && host_addr_i == `RTCW_OFF_IEN)
				ien_q <= host_wdata_i[1:0];
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_start;
		start_w && ien_q[0];
	endsequence
	sequence s_ctl_rd;
		host_rd_i && host_addr_i == `RTCW_OFF_CTRL;
	endsequence
	AST_RDATA_IDLE: assert property (!host_rd_i |=> host_rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	AST_ID_READ: assert property (host_rd_i && host_addr_i == `RTCW_OFF_ID |=> host_rdata_o == PERIPH_ID)
		else $error("id register read wrong");
	AST_IEN_READ: assert property (host_rd_i && host_addr_i == `RTCW_OFF_IEN |=> host_rdata_o == {30'h0, $past(ien_q)})
		else $error("irq enable read wrong");
	AST_BUSY_READ: assert property (s_ctl_rd |=> host_rdata_o[31] == ($past(busy_q) != 4'h0))
		else $error("busy bit wrong for transfer size");
	AST_XFER_IRQ: assert property (s_start |-> ##[6:10] host_irq_o)
		else $error("transfer done irq missing");
	AST_IRQ_MASKED: assert property (ien_q == 2'h0 |=> !host_irq_o)
		else $error("irq raised while masked");
	AST_TMR_PULSE: assert property (tmr_event_o |=> !tmr_event_o)
		else $error("timer event longer than one cycle");
	AST_WDOG_PULSE: assert property (wdog_event_o |=> !wdog_event_o)
		else $error("watchdog event longer than one cycle");
	AST_ALARM_PULSE: assert property (alarm_event_o |=> !alarm_event_o)
		else $error("alarm event longer than one cycle");
endmodule // rtcw_top_sva
bind rtcw_top rtcw_top_sva #(.PERIPH_ID(PERIPH_ID)) u_rtcw_top_sva (.clk_i(clk_i),
	.srst_i(srst_i), .host_addr_i(host_addr_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
	.host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_irq_o(host_irq_o),
	.tmr_event_o(tmr_event_o), .wdog_event_o(wdog_event_o), .alarm_event_o(alarm_event_o));
`default_nettype wire

// ==== verif/rtcw_top_test.sv ====
// self-checking bench for the rtc block through its host bridge
`timescale 1ns/100ps
`default_nettype none
`include "rtcw_defines.vh"
module rtcw_top_test;
	// ==========================================================
	// clock, reset, wiring
	// short enough that the first second tick lands near cycle 65536
	localparam int OSC = 2;
	localparam [31:0] ID = 32'h0000_5a5a; // arbitrary value
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	wire [7:0] addr_w;
	wire wr_w, rd_w, irq_w;
	wire [31:0] wd_w, rdat_w;
	wire [2:0] ev_w;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #4 clk_i = ~clk_i;
	rtcw_top #(.OSC_DIV(OSC), .PERIPH_ID(ID)) u_rtcw_top (.clk_i(clk_i), .srst_i(srst_i),
		.host_addr_i(addr_w), .host_wr_i(wr_w), .host_rd_i(rd_w), .host_wdata_i(wd_w),
		.host_rdata_o(rdat_w), .host_irq_o(irq_w), .tmr_event_o(ev_w[0]),
		.wdog_event_o(ev_w[1]), .alarm_event_o(ev_w[2]));
	rtcw_host u_rtcw_host (.clk_i(clk_i), .rdata_i(rdat_w), .addr_o(addr_w), .wr_o(wr_w),
		.rd_o(rd_w), .wdata_o(wd_w));
	// ==========================================================
	// checking helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// cycles between two pulses, sampled on the falling edge to avoid races
	task automatic gap(input int k, output int n);
		for (int i = 0; i < 400 && ev_w[k] !== 1'b1; i++)
			@(negedge clk_i);
		@(negedge clk_i);
		for (n = 1; n < 400 && ev_w[k] !== 1'b1; n++)
			@(negedge clk_i);
	endtask
	task automatic cnt(input int k, input int len, output int n);
		n = 0;
		repeat (len) begin
			@(negedge clk_i);
			if (ev_w[k] === 1'b1)
				n++;
		end
	endtask
	// a hang is cut short here
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_count++;
			test_done;
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [7:0] b;
		int n;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		u_rtcw_host.wr(`RTCW_OFF_ID, 32'hffff_ffff);
		u_rtcw_host.rd(`RTCW_OFF_ID, d);
		chk(d, ID);
		u_rtcw_host.rd(`RTCW_OFF_CTRL, d);
		chk(d, 32'h0);
		u_rtcw_host.rd(8'h18, d);
		chk(d, 32'h0);
		u_rtcw_host.sub_rd(`RTCW_SR_WDT, b);
		chk(b, 8'hff);
		u_rtcw_host.sub_rd(`RTCW_SR_CLKC, b);
		chk(b, 8'hb0);
		u_rtcw_host.wr(`RTCW_OFF_IEN, 32'hffff_ffff);
		u_rtcw_host.rd(`RTCW_OFF_IEN, d);
		chk(d, 32'h3);
		u_rtcw_host.wr(`RTCW_OFF_IEN, 32'h1);
		// 8-byte calendar write; a data write while busy must be dropped
		u_rtcw_host.wr(`RTCW_OFF_LDATA, 32'h0107_2358);
		u_rtcw_host.wr(`RTCW_OFF_UDATA, 32'h0006_4582);
		u_rtcw_host.wr(`RTCW_OFF_CTRL, 32'h02ff_0015);
		u_rtcw_host.wr(`RTCW_OFF_LDATA, 32'hdead_beef);
		u_rtcw_host.poll();
		u_rtcw_host.rd(`RTCW_OFF_LDATA, d);
		chk(d, 32'h0107_2358);
		chk(irq_w, 1'b1);
		u_rtcw_host.wr(`RTCW_OFF_IFLG, 32'h1);
		u_rtcw_host.rd(`RTCW_OFF_IFLG, d);
		chk(d[0], 1'b0);
		chk(irq_w, 1'b0);
		u_rtcw_host.hold(`RTCW_SR_CCTRL);
		u_rtcw_host.xfer(32'h0242_0015, 32'h0000_1100, 32'h0022_0000);
		u_rtcw_host.hold(`RTCW_SR_CCTRL);
		u_rtcw_host.xfer(32'h03ff_0015, 32'h0, 32'h0);
		u_rtcw_host.rd(`RTCW_OFF_LDATA, d);
		chk(d, 32'h0107_1158);
		u_rtcw_host.rd(`RTCW_OFF_UDATA, d);
		chk(d, 32'h0022_4502);
		// watchdog on fast ticks
		u_rtcw_host.sub_wr(`RTCW_SR_CLKC, 8'h00);
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h20);
		u_rtcw_host.sub_wr(`RTCW_SR_WDT, 8'h03);
		gap(1, n);
		chk(n, 4 * OSC);
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h30);
		u_rtcw_host.sub_rd(`RTCW_SR_CTRL, b);
		chk(b[6:4], 3'h6);
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h40);
		// timer one-shot, masked free-run, then free-run period
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h05);
		u_rtcw_host.sub_wr(`RTCW_SR_TMR0, 8'h05);
		u_rtcw_host.sub_wr(`RTCW_SR_TMR1, 8'h00);
		cnt(0, 200, n);
		chk(n, 1);
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h0b);
		u_rtcw_host.sub_wr(`RTCW_SR_TMR0, 8'h05);
		u_rtcw_host.sub_wr(`RTCW_SR_TMR1, 8'h00);
		cnt(0, 100, n);
		chk(n, 0);
		u_rtcw_host.sub_rd(`RTCW_SR_CTRL, b);
		chk(b[3], 1'b1);
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h07);
		gap(0, n);
		chk(n, 5 * OSC);
		u_rtcw_host.sub_wr(`RTCW_SR_CTRL, 8'h08);
		// hourly alarm: minute rolls 44 -> 45 and matches the stored alarm minute
		u_rtcw_host.sub_wr(`RTCW_SR_SEC, 8'h59);
		u_rtcw_host.sub_wr(`RTCW_SR_MIN, 8'h44);
		u_rtcw_host.sub_wr(`RTCW_SR_CCTRL, 8'h07);
		cnt(2, 66000, n);
		chk(n, 1);
		u_rtcw_host.sub_rd(`RTCW_SR_MIN, b);
		chk(b, 8'h45);
		u_rtcw_host.sub_rd(`RTCW_SR_SEC, b);
		chk(b, 8'h00);
		test_done;
	end
endmodule // rtcw_top_test
`default_nettype wire
